// file: pkg/phpms_defs.vh
`ifndef PHPMS_DEFS_VH
`define PHPMS_DEFS_VH

// ----------------------------------------------------------------
// Interface mode codes from the three strap bits
// ----------------------------------------------------------------
`define PHPMS_CFG_MII 3'h0
`define PHPMS_CFG_RMII 3'h1
`define PHPMS_CFG_SMII 3'h2
`define PHPMS_CFG_MII_PRE 3'h4
`define PHPMS_CFG_RMII_B2B 3'h5
`define PHPMS_CFG_MII_B2B 3'h6

// ----------------------------------------------------------------
// Strap reset values and fixed address bits
// ----------------------------------------------------------------
`define PHPMS_ADDR_RST 5'h01
`define PHPMS_ADDR_HI 2'h0
`define PHPMS_CFG_RST 3'h0
`define PHPMS_DUPLEX_RST 1'h0
`define PHPMS_ISO_RST 1'h0

// ----------------------------------------------------------------
// Sampled pin vector positions
// ----------------------------------------------------------------
`define PHPMS_P_RXD0 0
`define PHPMS_P_RXD1 1
`define PHPMS_P_RXD2 2
`define PHPMS_P_RXD3 3
`define PHPMS_P_RXDV 4
`define PHPMS_P_CRS 5
`define PHPMS_P_COL 6
`define PHPMS_P_RXER 7
`define PHPMS_P_REF 8
`define PHPMS_P_TXC 9
`define PHPMS_P_TXEN 10
`define PHPMS_P_TXD0 11
`define PHPMS_P_MDC 15
`define PHPMS_P_MDIO 16
`define PHPMS_NPINS 17

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PHPMS_CLK_MHZ 250
`define PHPMS_SETTLE_NS 16
`define PHPMS_SETTLE_CYC ((`PHPMS_SETTLE_NS*`PHPMS_CLK_MHZ+999)/1000)

// ----------------------------------------------------------------
// Receive FIFO shape: {err, valid, data[3:0]}
// ----------------------------------------------------------------
`define PHPMS_RXW 6
`define PHPMS_RXD 4

`endif

// file: rtl/phpms_fifo.v
`default_nettype none

// ----------------------------------------------------------------
// Small synchronous FIFO, valid/ready on both sides
// ----------------------------------------------------------------
module phpms_fifo #(
	parameter W = 6,
	parameter D = 4,
	parameter AW = 2
) (
	// Clock, reset, enable
	input wire clk,
	input wire reset_n,
	input wire clkEn,
	// Fill side
	input wire inValid,
	output wire inReady,
	input wire [W-1:0] inData,
	// Drain side
	output wire outValid,
	input wire outReady,
	output wire [W-1:0] outData
);

	reg [W-1:0] mem [0:D-1]; // Storage words
	reg [AW-1:0] wrPtr_r; // Write index
	reg [AW-1:0] rdPtr_r; // Read index
	reg [AW:0] count_r; // Words held
	wire doWr;
	wire doRd;

	// Honest full and empty from the count
	assign inReady = (count_r != D[AW:0]);
	assign outValid = (count_r != {(AW+1){1'b0}});
	assign outData = mem[rdPtr_r];
	assign doWr = inValid & inReady;
	assign doRd = outValid & outReady;

	// Pointers and count; frozen while clkEn is low
	always @(posedge clk) begin
		if (!reset_n) begin
			wrPtr_r <= {AW{1'b0}};
			rdPtr_r <= {AW{1'b0}};
			count_r <= {(AW+1){1'b0}};
		end else if (clkEn) begin
			if (doWr)
				wrPtr_r <= wrPtr_r + 1'b1;
			if (doRd)
				rdPtr_r <= rdPtr_r + 1'b1;
			if (doWr & ~doRd)
				count_r <= count_r + 1'b1;
			else if (doRd & ~doWr)
				count_r <= count_r - 1'b1;
		end
	end

	// Storage write, no reset needed on data
	always @(posedge clk) begin
		if (clkEn & doWr)
			mem[wrPtr_r] <= inData;
	end

endmodule

`default_nettype wire

// file: rtl/phpms_pin_mux.v
// How it works
// - Receive data 3,2,1 straps become address bits 0-2
// - Receive data 0 strap captured as duplex
// - Valid, carrier, collision straps give mode bits 2-0
// - Receive error strap captured as isolate
// - Strap pins undriven in reset and settling, then outputs per mode unless isolated
// - Mode code selects MII, RMII, SMII or variants
// - Upper two address bits always zero
// - Interrupt pin polarity selectable, active low default
// - Transmit clock driven in MII, input in back-to-back MII
// - Management clock input, data pin bidirectional
// - MII: four data, valid, clock, error, carrier, collision
// - RMII: carrier/valid, two data bits, error
// - SMII: serial receive stream on data bit 0
`include "phpms_defs.vh"
`default_nettype none

module phpms_pin_mux (
	// Clock, reset, enable
	input wire clk,
	input wire reset_n,
	input wire clkEn,
	// Reference clock pin
	input wire refClockIn,
	// Strap-shared receive pins
	input wire [3:0] rxdIn,
	output reg [3:0] rxdOut,
	output reg [3:0] rxdOe,
	input wire rxdvIn,
	output reg rxdvOut,
	output reg rxdvOe,
	input wire crsIn,
	output reg crsOut,
	output reg crsOe,
	input wire colIn,
	output reg colOut,
	output reg colOe,
	input wire rxerIn,
	output reg rxerOut,
	output reg rxerOe,
	// Receive clock pin
	output reg rxClkOut,
	// Transmit pins
	input wire txcIn,
	output reg txcOut,
	output reg txcOe,
	input wire txEnIn,
	input wire [3:0] txdIn,
	// Management pins
	input wire mdcIn,
	input wire mdioIn,
	output reg mdioOut,
	output reg mdioOe,
	// Interrupt pin
	output reg irqOut,
	// Core receive stream
	input wire rxWordValid,
	output wire rxWordReady,
	input wire [3:0] rxWordData,
	input wire rxWordDv,
	input wire rxWordErr,
	input wire carrierSense,
	input wire collision,
	// Core transmit stream
	output reg txStrobe,
	output reg txEnable,
	output reg [3:0] txData,
	// Core management side
	output reg mdcLevel,
	output reg mdioInLevel,
	input wire mgmtDataOut,
	input wire mgmtDataOe,
	// Core interrupt side
	input wire irqPending,
	input wire irqActiveHigh,
	// Captured straps
	output reg [4:0] mgmtAddress,
	output reg duplexStrap,
	output reg isolateStrap,
	output reg ifaceCfgBit2,
	output reg ifaceCfgBit1,
	output reg ifaceCfgBit0,
	output reg strapDone
);

	// ------------------------------------------------------------
	// Constants
	// ------------------------------------------------------------
	localparam ST_WAIT = 1'b0; // Settling after reset release
	localparam ST_RUN = 1'b1; // Straps held, pins driven
	localparam [31:0] SETTLE_LAST = `PHPMS_SETTLE_CYC - 1;
	localparam [3:0] SETTLE_LAST4 = SETTLE_LAST[3:0];

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	wire [`PHPMS_NPINS-1:0] pinRaw; // All pins from outside
	wire [`PHPMS_NPINS-1:0] pinF; // Filtered, agreed levels
	reg state_r; // Strap sequencer state
	reg [3:0] settle_r; // Settling counter
	reg refPrev_r; // Last filtered reference level
	reg txcPrev_r; // Last filtered transmit clock level
	wire [2:0] cfg; // Captured mode code
	wire modeMii;
	wire modeRmii;
	wire modeSmii;
	wire miiB2b;
	wire refEdge;
	wire txcEdge;
	wire sampleEdge;
	wire drive; // Pins may be driven now
	wire fifoValid;
	wire fifoReady;
	wire [`PHPMS_RXW-1:0] fifoWord;

	assign pinRaw = {mdioIn, mdcIn, txdIn, txEnIn, txcIn, refClockIn,
		rxerIn, colIn, crsIn, rxdvIn, rxdIn};

	// Three stages per pin, then accept a change only on agreement
	genvar gi;
	generate
		for (gi = 0; gi < `PHPMS_NPINS; gi = gi + 1) begin : gSync
			reg s1_r; // First stage, read only by s2_r
			reg s2_r;
			reg s3_r;
			reg f_r; // Filtered level
			// No reset here: the pulls settle while reset is held,
			// so capture reads them and not a cleared filter
			always @(posedge clk) begin
				if (clkEn) begin
					s1_r <= pinRaw[gi];
					s2_r <= s1_r;
					s3_r <= s2_r;
					if (s2_r == s3_r)
						f_r <= s3_r;
				end
			end
			assign pinF[gi] = f_r;
		end
	endgenerate

	// ------------------------------------------------------------
	// Mode decode and link clock edges
	// ------------------------------------------------------------
	assign cfg = {ifaceCfgBit2, ifaceCfgBit1, ifaceCfgBit0};
	assign modeMii = (cfg == `PHPMS_CFG_MII) |
		(cfg == `PHPMS_CFG_MII_PRE) | (cfg == `PHPMS_CFG_MII_B2B);
	assign modeRmii = (cfg == `PHPMS_CFG_RMII) |
		(cfg == `PHPMS_CFG_RMII_B2B);
	assign modeSmii = (cfg == `PHPMS_CFG_SMII);
	assign miiB2b = (cfg == `PHPMS_CFG_MII_B2B);
	// Reserved codes leave every data pin idle
	assign refEdge = pinF[`PHPMS_P_REF] & ~refPrev_r;
	assign txcEdge = pinF[`PHPMS_P_TXC] & ~txcPrev_r;
	// Back-to-back MII takes transmit timing from the partner
	assign sampleEdge = miiB2b ? txcEdge : refEdge;
	// Isolate keeps the data pins off the bus
	assign drive = (state_r == ST_RUN) & ~isolateStrap;
	assign fifoReady = (state_r == ST_RUN) & refEdge;

	// ------------------------------------------------------------
	// Receive FIFO; core stalls on rxWordReady when full
	// ------------------------------------------------------------
	phpms_fifo #(
		.W(`PHPMS_RXW),
		.D(`PHPMS_RXD),
		.AW(2)
	) uFifo (
		.clk(clk),
		.reset_n(reset_n),
		.clkEn(clkEn),
		.inValid(rxWordValid),
		.inReady(rxWordReady),
		.inData({rxWordErr, rxWordDv, rxWordData}),
		.outValid(fifoValid),
		.outReady(fifoReady),
		.outData(fifoWord)
	);

	// ------------------------------------------------------------
	// Strap sequencer and capture
	// ------------------------------------------------------------
	// Capture waits for the synchronisers to fill after release
	always @(posedge clk) begin
		if (!reset_n) begin
			state_r <= ST_WAIT;
			settle_r <= 4'h0;
			strapDone <= 1'b0;
			mgmtAddress <= `PHPMS_ADDR_RST;
			duplexStrap <= `PHPMS_DUPLEX_RST;
			isolateStrap <= `PHPMS_ISO_RST;
			{ifaceCfgBit2, ifaceCfgBit1, ifaceCfgBit0} <= `PHPMS_CFG_RST;
		end else if (clkEn) begin
			case (state_r)
				ST_WAIT: begin
					if (settle_r == SETTLE_LAST4) begin
						mgmtAddress <= {`PHPMS_ADDR_HI,
							pinF[`PHPMS_P_RXD1], pinF[`PHPMS_P_RXD2],
							pinF[`PHPMS_P_RXD3]};
						duplexStrap <= pinF[`PHPMS_P_RXD0];
						ifaceCfgBit2 <= pinF[`PHPMS_P_RXDV];
						ifaceCfgBit1 <= pinF[`PHPMS_P_CRS];
						ifaceCfgBit0 <= pinF[`PHPMS_P_COL];
						isolateStrap <= pinF[`PHPMS_P_RXER];
						strapDone <= 1'b1;
						state_r <= ST_RUN;
					end else begin
						settle_r <= settle_r + 4'h1;
					end
				end
				ST_RUN: begin
					state_r <= ST_RUN; // Held until next reset
				end
				default: begin
					state_r <= ST_WAIT;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Output enables of strap-shared pins and transmit clock
	// ------------------------------------------------------------
	// Enables low through reset and settling keep pulls readable
	always @(posedge clk) begin
		if (!reset_n) begin
			rxdOe <= 4'h0;
			rxdvOe <= 1'b0;
			crsOe <= 1'b0;
			colOe <= 1'b0;
			rxerOe <= 1'b0;
			txcOe <= 1'b0;
		end else if (clkEn) begin
			rxdOe <= {{2{drive & modeMii}},
				{drive & (modeMii | modeRmii)},
				{drive & (modeMii | modeRmii | modeSmii)}};
			rxdvOe <= drive & (modeMii | modeRmii);
			crsOe <= drive & modeMii;
			colOe <= drive & modeMii;
			rxerOe <= drive & (modeMii | modeRmii);
			txcOe <= drive & modeMii & ~miiB2b;
		end
	end

	// ------------------------------------------------------------
	// Receive pin data, one FIFO word per reference rising edge
	// ------------------------------------------------------------
	always @(posedge clk) begin
		if (!reset_n) begin
			rxdOut <= 4'h0;
			rxdvOut <= 1'b0;
			crsOut <= 1'b0;
			colOut <= 1'b0;
			rxerOut <= 1'b0;
			rxClkOut <= 1'b0;
			txcOut <= 1'b0;
			refPrev_r <= 1'b0;
			txcPrev_r <= 1'b0;
		end else if (clkEn) begin
			refPrev_r <= pinF[`PHPMS_P_REF];
			txcPrev_r <= pinF[`PHPMS_P_TXC];
			// Clock pins follow the filtered reference
			rxClkOut <= drive & modeMii & pinF[`PHPMS_P_REF];
			txcOut <= drive & modeMii & pinF[`PHPMS_P_REF];
			if (fifoReady) begin
				// Empty FIFO gives an idle word
				if (modeMii) begin
					rxdOut <= fifoValid ? fifoWord[3:0] : 4'h0;
					rxdvOut <= fifoValid & fifoWord[4];
					rxerOut <= fifoValid & fifoWord[5];
					crsOut <= carrierSense;
					colOut <= collision;
				end else if (modeRmii) begin
					rxdOut <= {2'h0, fifoValid ? fifoWord[1:0] : 2'h0};
					rxdvOut <= carrierSense |
						(fifoValid & fifoWord[4]);
					rxerOut <= fifoValid & fifoWord[5];
					crsOut <= 1'b0;
					colOut <= 1'b0;
				end else if (modeSmii) begin
					rxdOut <= {3'h0, fifoValid & fifoWord[0]};
					rxdvOut <= 1'b0;
					rxerOut <= 1'b0;
					crsOut <= 1'b0;
					colOut <= 1'b0;
				end else begin
					rxdOut <= 4'h0;
					rxdvOut <= 1'b0;
					rxerOut <= 1'b0;
					crsOut <= 1'b0;
					colOut <= 1'b0;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Transmit pin sampling toward the core
	// ------------------------------------------------------------
	// In SMII bit 0 is the serial stream and bit 1 the sync pulse
	always @(posedge clk) begin
		if (!reset_n) begin
			txStrobe <= 1'b0;
			txEnable <= 1'b0;
			txData <= 4'h0;
		end else if (clkEn) begin
			txStrobe <= (state_r == ST_RUN) & sampleEdge;
			if ((state_r == ST_RUN) & sampleEdge) begin
				txEnable <= (modeMii | modeRmii) & pinF[`PHPMS_P_TXEN];
				if (modeMii)
					txData <= pinF[`PHPMS_P_TXD0+3:`PHPMS_P_TXD0];
				else if (modeRmii | modeSmii)
					txData <= {2'h0,
						pinF[`PHPMS_P_TXD0+1:`PHPMS_P_TXD0]};
				else
					txData <= 4'h0;
			end
		end
	end

	// ------------------------------------------------------------
	// Management pins and interrupt pin
	// ------------------------------------------------------------
	// Core decodes frames on mdcLevel edges; data pin is tri-state
	always @(posedge clk) begin
		if (!reset_n) begin
			mdcLevel <= 1'b0;
			mdioInLevel <= 1'b0;
			mdioOut <= 1'b0;
			mdioOe <= 1'b0;
			irqOut <= 1'b1;
		end else if (clkEn) begin
			mdcLevel <= pinF[`PHPMS_P_MDC];
			mdioInLevel <= pinF[`PHPMS_P_MDIO];
			mdioOut <= mgmtDataOut;
			mdioOe <= mgmtDataOe;
			irqOut <= irqActiveHigh ? irqPending : ~irqPending;
		end
	end

endmodule

`default_nettype wire

// file: tb/phpms_pin_mux_sva.sv
`default_nettype none
// ----------------
// Pin mux checker
// ----------------
module phpms_pin_mux_sva (
	// Clock and control
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clkEn,
	// Pin drive
	input wire logic [3:0] rxdOe,
	input wire logic rxdvOe,
	input wire logic crsOe,
	input wire logic colOe,
	input wire logic rxerOe,
	input wire logic txcOe,
	input wire logic mdioOut,
	input wire logic mdioOe,
	input wire logic irqOut,
	// Core side
	input wire logic mgmtDataOut,
	input wire logic mgmtDataOe,
	input wire logic irqPending,
	input wire logic irqActiveHigh,
	// Captured straps
	input wire logic [4:0] mgmtAddress,
	input wire logic isolateStrap,
	input wire logic ifaceCfgBit2,
	input wire logic ifaceCfgBit1,
	input wire logic ifaceCfgBit0,
	input wire logic strapDone
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	// Mode code and drive on any strap pin
	wire logic [2:0] cfg;
	wire logic anyOe;
	assign cfg = {ifaceCfgBit2, ifaceCfgBit1, ifaceCfgBit0};
	assign anyOe = |{rxdOe, rxdvOe, crsOe, colOe, rxerOe};
	// Pulls must be sampled undisturbed
	property p_quiet;
		!strapDone |-> !anyOe;
	endproperty
	a_quiet: assert property (p_quiet) else $error("early drive");
	// Capture lands four edges after release
	property p_doneTime;
		$rose(reset_n) |-> !strapDone[*4] ##1 strapDone;
	endproperty
	a_doneTime: assert property (p_doneTime) else $error("late");
	property p_addrHi;
		strapDone |-> mgmtAddress[4:3] == 2'h0;
	endproperty
	a_addrHi: assert property (p_addrHi) else $error("addr hi");
	// Clock pin driven only in plain MII modes
	property p_txcOe;
		txcOe |-> strapDone && !isolateStrap && cfg[1:0] == 2'h0;
	endproperty
	a_txcOe: assert property (p_txcOe) else $error("txc drive");
	property p_isolate;
		strapDone && isolateStrap |-> rxdOe == 4'h0 && !txcOe;
	endproperty
	a_isolate: assert property (p_isolate) else $error("iso");
	// Reserved codes leave every strap pin undriven
	property p_reserved;
		strapDone && cfg[1:0] == 2'h3 |-> !anyOe;
	endproperty
	a_reserved: assert property (p_reserved) else $error("rsvd");
	property p_mdio;
		clkEn |=> mdioOe == $past(mgmtDataOe) && mdioOut == $past(mgmtDataOut);
	endproperty
	a_mdio: assert property (p_mdio) else $error("mdio");
	property p_irq;
		clkEn |=> irqOut == ($past(irqPending) ^ !$past(irqActiveHigh));
	endproperty
	a_irq: assert property (p_irq) else $error("irq");
	// Main scenarios
	c_done: cover property ($rose(strapDone));
	c_iso: cover property (strapDone && isolateStrap);
	c_mdio: cover property (mdioOe && mdioOut);
endmodule
`default_nettype wire

// file: tb/phpms_mac_model.sv
`default_nettype none
// ----------------
// Board and MAC model
// ----------------
module phpms_mac_model (
	// Bench controls: {rxer,col,crs,rxdv,rxd3..0} pulls
	input wire logic [7:0] pulls,
	input wire logic refRun,
	input wire logic mstLow,
	// Device pin drive
	input wire logic [3:0] rxdOut,
	input wire logic [3:0] rxdOe,
	input wire logic rxdvOut,
	input wire logic rxdvOe,
	input wire logic crsOut,
	input wire logic crsOe,
	input wire logic colOut,
	input wire logic colOe,
	input wire logic rxerOut,
	input wire logic rxerOe,
	input wire logic mdioOut,
	input wire logic mdioOe,
	// Resolved pin levels
	output wire logic [3:0] rxdIn,
	output wire logic rxdvIn,
	output wire logic crsIn,
	output wire logic colIn,
	output wire logic rxerIn,
	output wire logic mdioIn,
	output var logic refClockIn
);
	timeunit 1ns;
	timeprecision 1ps;
	// Weak pull shows only where the device lets go
	assign rxdIn = (rxdOe & rxdOut) | (~rxdOe & pulls[3:0]);
	assign rxdvIn = rxdvOe ? rxdvOut : pulls[4];
	assign crsIn = crsOe ? crsOut : pulls[5];
	assign colIn = colOe ? colOut : pulls[6];
	assign rxerIn = rxerOe ? rxerOut : pulls[7];
	// Pulled-up shared data line; either side may pull low
	assign mdioIn = !(mstLow || (mdioOe && !mdioOut));
	// Reference clock; halting it stalls the receive drain
	initial refClockIn = 1'b0;
	always #32 if (refRun) refClockIn = ~refClockIn;
endmodule
`default_nettype wire

// file: tb/testbench.sv
`default_nettype none
// ----------------
// Pin mux bench
// ----------------
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	// Bench-driven inputs
	logic clk, reset_n, clkEn, txEnIn, mdcIn, refRun, mstLow;
	logic rxWordValid, rxWordDv, rxWordErr, carrierSense, collision;
	logic mgmtDataOut, mgmtDataOe, irqPending, irqActiveHigh;
	logic [3:0] txdIn, rxWordData;
	logic [7:0] pulls;
	// Pin levels and device outputs
	wire logic [3:0] rxdIn, rxdOut, rxdOe, txData;
	wire logic [4:0] mgmtAddress;
	wire logic rxdvIn, crsIn, colIn, rxerIn, mdioIn, refClockIn, txcIn;
	wire logic rxdvOut, rxdvOe, crsOut, crsOe, colOut, colOe, rxerOut, rxerOe;
	wire logic rxClkOut, txcOut, txcOe, mdioOut, mdioOe, irqOut, rxWordReady;
	wire logic txStrobe, txEnable, mdcLevel, mdioInLevel, duplexStrap;
	wire logic isolateStrap, ifaceCfgBit2, ifaceCfgBit1, ifaceCfgBit0, strapDone;
	int n_errors = 0;
	int num_checks = 0;
	phpms_pin_mux dut_u (.clk, .reset_n, .clkEn, .refClockIn, .rxdIn, .rxdOut,
		.rxdOe, .rxdvIn, .rxdvOut, .rxdvOe, .crsIn, .crsOut, .crsOe, .colIn,
		.colOut, .colOe, .rxerIn, .rxerOut, .rxerOe, .rxClkOut, .txcIn, .txcOut,
		.txcOe, .txEnIn, .txdIn, .mdcIn, .mdioIn, .mdioOut, .mdioOe, .irqOut,
		.rxWordValid, .rxWordReady, .rxWordData, .rxWordDv, .rxWordErr,
		.carrierSense, .collision, .txStrobe, .txEnable, .txData, .mdcLevel,
		.mdioInLevel, .mgmtDataOut, .mgmtDataOe, .irqPending, .irqActiveHigh,
		.mgmtAddress, .duplexStrap, .isolateStrap, .ifaceCfgBit2, .ifaceCfgBit1,
		.ifaceCfgBit0, .strapDone);
	phpms_mac_model mac_u (.pulls, .refRun, .mstLow, .rxdOut, .rxdOe, .rxdvOut,
		.rxdvOe, .crsOut, .crsOe, .colOut, .colOe, .rxerOut, .rxerOe, .mdioOut,
		.mdioOe, .rxdIn, .rxdvIn, .crsIn, .colIn, .rxerIn, .mdioIn, .refClockIn);
	// Partner's transmit clock, used only in back-to-back MII
	assign txcIn = ~refClockIn;
	// 250 MHz clock
	initial clk = 1'b0;
	always #2 clk = ~clk;
	// Inputs move 1 ns after the edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Reset with new pulls, wait bounded for capture
	task automatic restart(input logic [7:0] p);
		int k;
		pulls = p;
		reset_n = 1'b0;
		tick(20);
		reset_n = 1'b1;
		for (k = 0; k < 20 && strapDone !== 1'b1; k++) tick(1);
	endtask
	// Push one word; valid stays up for back-to-back use
	task automatic push(input logic [5:0] w);
		int k;
		{rxWordErr, rxWordDv, rxWordData} = w;
		rxWordValid = 1'b1;
		for (k = 0; k < 40 && rxWordReady !== 1'b1; k++) tick(1);
		tick(1);
	endtask
	task automatic waitRx(input logic [5:0] prev);
		int k;
		for (k = 0; k < 40 && {rxerOut, rxdvOut, rxdOut} === prev; k++) tick(1);
	endtask
	initial begin
		logic [2:0] a;
		logic [2:0] c;
		logic mii;
		logic rmii;
		logic [5:0] w;
		logic [5:0] words [4];
		int i;
		int k;
		words = '{6'h15, 6'h3A, 6'h13, 6'h1C};
		{reset_n, mdcIn, mstLow, rxWordValid, rxWordDv} = 5'h00;
		{rxWordErr, carrierSense, collision, mgmtDataOut, mgmtDataOe} = 5'h00;
		{irqPending, clkEn, txEnIn, refRun, irqActiveHigh} = 5'h0E;
		{txdIn, rxWordData, pulls} = 16'h6000;
		// Every mode code, varied address, isolate last
		for (i = 0; i < 9; i++) begin
			c = i[2:0];
			a = 3'(i * 5 + 1);
			// Expected drive per mode code, none when isolated
			mii = i < 8 && (c == 3'h0 || c == 3'h4 || c == 3'h6);
			rmii = i < 8 && (c == 3'h1 || c == 3'h5);
			restart({i == 8, c[0], c[1], c[2], a[0], a[1], a[2], !i[0]});
			tick(2);
			pulls = ~pulls;
			tick(8);
			chk(8'(mgmtAddress), 8'(a));
			chk(8'(duplexStrap), 8'(!i[0]));
			chk(8'({ifaceCfgBit2, ifaceCfgBit1, ifaceCfgBit0}), 8'(c));
			chk(8'(isolateStrap), 8'(i == 8));
			chk(8'(txcOe), 8'(i < 8 && c[1:0] == 2'h0));
			chk(8'(rxdOe[0]), 8'(i < 8 && c[1:0] != 2'h3));
			chk(8'(rxdOe[3:1]), 8'({mii, mii, mii | rmii}));
			chk(8'({crsOe, colOe, rxdvOe, rxerOe}),
				8'({mii, mii, mii | rmii, mii | rmii}));
			for (k = 0; k < 40 && txStrobe !== 1'b1; k++) tick(1);
			if (i == 0) chk(8'({txEnable, txData}), 8'h16);
			if (i == 1) chk(8'({txEnable, txData}), 8'h12);
			if (i == 2) chk(8'({txEnable, txData[1:0]}), 8'h02);
			if (i == 6) chk(8'({txEnable, txData}), 8'h16);
		end
		$display("test straps done");
		// Fill while the reference stalls, then drain in order
		restart(8'h08);
		chk(8'({rxerOut, rxdvOut, rxdOut}), 8'h00);
		refRun = 1'b0;
		tick(40);
		for (i = 0; i < 4; i++) push(words[i]);
		chk(8'(rxWordReady), 8'h00);
		rxWordValid = 1'b0;
		carrierSense = 1'b1;
		refRun = 1'b1;
		w = 6'h00;
		for (i = 0; i < 4; i++) begin
			waitRx(w);
			w = words[i];
			chk(8'({rxerOut, rxdvOut, rxdOut}), 8'(w));
			chk(8'({rxClkOut, txcOut}), 8'h03);
		end
		waitRx(w);
		chk(8'({rxerOut, rxdvOut, rxdOut}), 8'h00);
		chk(8'({colOut, crsOut}), 8'h01);
		$display("test receive done");
		// Interrupt pin in both polarities
		for (i = 0; i < 4; i++) begin
			{irqActiveHigh, irqPending} = 2'(i);
			tick(2);
			chk(8'(irqOut), 8'(i[0] ^ !i[1]));
		end
		// Enable low freezes the pin, release lets it follow
		clkEn = 1'b0;
		irqPending = 1'b0;
		tick(4);
		chk(8'(irqOut), 8'h01);
		clkEn = 1'b1;
		tick(2);
		chk(8'(irqOut), 8'h00);
		// Management clock and shared data line
		mdcIn = 1'b1;
		mstLow = 1'b1;
		tick(8);
		chk(8'({mdcLevel, mdioInLevel}), 8'h02);
		{mstLow, mgmtDataOe, mgmtDataOut} = 3'h3;
		tick(8);
		chk(8'({mdioOe, mdioOut, mdioInLevel}), 8'h07);
		$display("test irq and mgmt done");
		test_done();
	end
	// Watchdog well beyond the expected run
	initial begin
		#100000;
		n_errors++;
		test_done();
	end
endmodule
bind phpms_pin_mux phpms_pin_mux_sva chk_u (.clk, .reset_n, .clkEn, .rxdOe,
	.rxdvOe, .crsOe, .colOe, .rxerOe, .txcOe, .mdioOut, .mdioOe, .irqOut,
	.mgmtDataOut, .mgmtDataOe, .irqPending, .irqActiveHigh, .mgmtAddress,
	.isolateStrap, .ifaceCfgBit2, .ifaceCfgBit1, .ifaceCfgBit0, .strapDone);
`default_nettype wire
